// file: hdl/bcs_pkg.sv
package bcs_pkg;

    // register offsets on the management port
    localparam logic [7:0] ADDR_BUCK_TWO   = 8'h06;
    localparam logic [7:0] ADDR_BUCK_THREE = 8'h07;

    // field positions inside each status byte
    localparam int BIT_FAULT      = 7;
    localparam int BIT_RETRY      = 6;
    localparam int BIT_NEG_LIMIT  = 5;
    localparam int BIT_ZERO_CROSS = 4;
    localparam int BIT_RESERVED   = 3;
    localparam int BIT_SOFT_START = 2;
    localparam int BIT_POWER_GOOD = 1;
    localparam int BIT_ENABLE     = 0;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET  = 4'h0;

    // number of high-side overcurrent events that ends the count
    localparam int HSOC_END_COUNT = 8;
    localparam int HSOC_CNT_W     = $clog2(HSOC_END_COUNT + 1);

    // flag vector index inside the 4-bit latched group (bits 7..4)
    localparam int FL_FAULT = 3;
    localparam int FL_RETRY = 2;
    localparam int FL_NEG   = 1;
    localparam int FL_ZERO  = 0;

    // assemble one status byte from latched flags and live indications
    function automatic logic [7:0] status_byte(input logic [3:0] flags,
                                               input logic       softStartDone,
                                               input logic       powerGood,
                                               input logic       enableStatus);
        logic [7:0] b;
        b                 = STATUS_RESET;
        b[BIT_FAULT]      = flags[FL_FAULT];
        b[BIT_RETRY]      = flags[FL_RETRY];
        b[BIT_NEG_LIMIT]  = flags[FL_NEG];
        b[BIT_ZERO_CROSS] = flags[FL_ZERO];
        b[BIT_RESERVED]   = 1'b0;
        b[BIT_SOFT_START] = softStartDone;
        b[BIT_POWER_GOOD] = powerGood;
        b[BIT_ENABLE]     = enableStatus;
        return b;
    endfunction

endpackage

// file: hdl/bcs_flag_latch.sv
`timescale 1ns/100ps

// four sticky flags: a set always beats a clear in the same cycle
module bcs_flag_latch (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic [3:0] setFlags,
    input  wire logic       clearFlags,
    output logic      [3:0] flags
);

    logic [3:0] next_flags;

    ////////////////////////////////////////////////////////////////////////////
    // next value: hold, clear on read, set wins
    always_comb begin
        next_flags = flags;
        if (ce) begin
            next_flags = (flags & ~{4{clearFlags}}) | setFlags;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= bcs_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

endmodule // bcs_flag_latch

// file: hdl/bcs_event_counter.sv
`timescale 1ns/100ps

// counts high-side overcurrent events while power is not good
module bcs_event_counter (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic overcurrentEvent,
    input  wire logic powerGood,
    output logic      endReached
);

    logic [bcs_pkg::HSOC_CNT_W-1:0] count;
    logic [bcs_pkg::HSOC_CNT_W-1:0] next_count;
    logic                           next_endReached;

    localparam logic [bcs_pkg::HSOC_CNT_W-1:0] LAST =
        bcs_pkg::HSOC_CNT_W'(bcs_pkg::HSOC_END_COUNT - 1);

    ////////////////////////////////////////////////////////////////////////////
    // a good output restarts the count, so isolated events never add up
    always_comb begin
        next_count      = count;
        next_endReached = 1'b0;
        if (ce) begin
            if (powerGood) begin
                next_count = '0;
            end else if (overcurrentEvent) begin
                if (count == LAST) begin
                    next_count      = '0;
                    next_endReached = 1'b1;
                end else begin
                    next_count = count + 1'b1;
                end
            end
        end else begin
            next_endReached = endReached;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count      <= '0;
            endReached <= 1'b0;
        end else begin
            count      <= next_count;
            endReached <= next_endReached;
        end
    end

endmodule // bcs_event_counter

// file: hdl/bcs_status_regs.sv
`timescale 1ns/100ps

// Notes on behaviour
// - status bytes for buck two and three at 0x06/0x07
// - fault flag on retry or enabled-ramped-not-good
// - retry flag when overcurrent count ends, power bad
// - retry enable picks restart or latch-off reaction
// - negative limit flag latched on threshold reached
// - zero-cross flag latched in auto pulse-skip trips
// - bit 3 reserved, reads zero
// - soft-start-done live: enabled and ramp finished
// - power-good bit is live comparator output
// - enable-status bit is live enable
// - read clears bits 7..4; reset zeroes everything
module bcs_status_regs (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       readStrobe,
    input  wire logic [7:0] readAddr,
    input  wire logic [1:0] regulatorEnabled,
    input  wire logic [1:0] rampFinished,
    input  wire logic [1:0] powerGoodCmp,
    input  wire logic [1:0] highSideOvercurrent,
    input  wire logic [1:0] negativeLimitHit,
    input  wire logic [1:0] autoPulseSkipMode,
    input  wire logic [1:0] zeroCrossTrip,
    input  wire logic       retryResponseEnable,
    output logic      [7:0] readData,
    output logic            readValid,
    output logic      [1:0] retryRestart,
    output logic      [1:0] retryLatchOff
);

    logic [3:0] flags      [2];
    logic [3:0] setFlags   [2];
    logic [1:0] clearFlags;
    logic [1:0] endReached;
    logic [1:0] softStartDone;
    logic [1:0] hitTwo;
    logic [7:0] next_readData;
    logic       next_readValid;
    logic [1:0] next_retryRestart;
    logic [1:0] next_retryLatchOff;

    ////////////////////////////////////////////////////////////////////////////
    // per-channel flag sources; index 0 is buck two, index 1 is buck three
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            softStartDone[c] = regulatorEnabled[c] & rampFinished[c];
            setFlags[c]      = bcs_pkg::FLAGS_RESET;
            setFlags[c][bcs_pkg::FL_RETRY] = endReached[c] & ~powerGoodCmp[c];
            setFlags[c][bcs_pkg::FL_NEG]   = negativeLimitHit[c];
            // zero-cross detection only runs in auto pulse-skip mode
            setFlags[c][bcs_pkg::FL_ZERO]  = autoPulseSkipMode[c] & zeroCrossTrip[c];
            // fault follows the retry flag, latched or arriving; a read drops both together
            setFlags[c][bcs_pkg::FL_FAULT] = (flags[c][bcs_pkg::FL_RETRY] & ~clearFlags[c])
                                           | setFlags[c][bcs_pkg::FL_RETRY]
                                           | (regulatorEnabled[c] & softStartDone[c]
                                              & ~powerGoodCmp[c]);
        end
    end

    // a read of a channel's byte clears that channel's latched group
    always_comb begin
        hitTwo[0]     = readAddr == bcs_pkg::ADDR_BUCK_TWO;
        hitTwo[1]     = readAddr == bcs_pkg::ADDR_BUCK_THREE;
        clearFlags[0] = readStrobe & hitTwo[0];
        clearFlags[1] = readStrobe & hitTwo[1];
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        bcs_event_counter u_count (
            .clk              (clk),
            .reset_n          (reset_n),
            .ce               (ce),
            .overcurrentEvent (highSideOvercurrent[g]),
            .powerGood        (powerGoodCmp[g]),
            .endReached       (endReached[g])
        );
        bcs_flag_latch u_flags (
            .clk        (clk),
            .reset_n    (reset_n),
            .ce         (ce),
            .setFlags   (setFlags[g]),
            .clearFlags (clearFlags[g]),
            .flags      (flags[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data captured before the clear takes effect; unmapped reads 0
    always_comb begin
        next_readData  = readData;
        next_readValid = readValid;
        if (ce) begin
            next_readValid = readStrobe;
            next_readData  = bcs_pkg::STATUS_RESET;
            if (readStrobe) begin
                for (int c = 0; c < 2; c++) begin
                    if (hitTwo[c]) begin
                        next_readData = bcs_pkg::status_byte(flags[c], softStartDone[c],
                                            powerGoodCmp[c], regulatorEnabled[c]);
                    end
                end
            end
        end
    end

    // reaction to a new retry event: restart pulse or latch-off pulse
    always_comb begin
        next_retryRestart  = retryRestart;
        next_retryLatchOff = retryLatchOff;
        if (ce) begin
            for (int c = 0; c < 2; c++) begin
                next_retryRestart[c]  = setFlags[c][bcs_pkg::FL_RETRY]
                                        & retryResponseEnable;
                next_retryLatchOff[c] = setFlags[c][bcs_pkg::FL_RETRY]
                                        & ~retryResponseEnable;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData      <= bcs_pkg::STATUS_RESET;
            readValid     <= 1'b0;
            retryRestart  <= 2'h0;
            retryLatchOff <= 2'h0;
        end else begin
            readData      <= next_readData;
            readValid     <= next_readValid;
            retryRestart  <= next_retryRestart;
            retryLatchOff <= next_retryLatchOff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks, shown on buck two; buck three shares the same logic
    property p_reserved_zero;
        @(posedge clk) disable iff (!reset_n)
        readValid |-> readData[bcs_pkg::BIT_RESERVED] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read as one");

    property p_unmapped_zero;
        @(posedge clk) disable iff (!reset_n)
        (ce && readStrobe && !hitTwo[0] && !hitTwo[1]) |=> readValid && readData == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned data");

    property p_fault_set;
        @(posedge clk) disable iff (!reset_n)
        (ce && regulatorEnabled[0] && rampFinished[0] && !powerGoodCmp[0])
            |=> flags[0][bcs_pkg::FL_FAULT];
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault flag missed power-good loss");

    property p_retry_set;
        @(posedge clk) disable iff (!reset_n)
        (ce && endReached[0] && !powerGoodCmp[0])
            |=> flags[0][bcs_pkg::FL_RETRY] && flags[0][bcs_pkg::FL_FAULT];
    endproperty
    a_retry_set: assert property (p_retry_set)
        else $error("retry flag or following fault not latched");

    property p_neg_limit;
        @(posedge clk) disable iff (!reset_n)
        (ce && negativeLimitHit[0] && clearFlags[0]) |=> flags[0][bcs_pkg::FL_NEG];
    endproperty
    a_neg_limit: assert property (p_neg_limit)
        else $error("negative limit lost during clearing read");

    property p_zero_cross_cause;
        @(posedge clk) disable iff (!reset_n)
        $rose(flags[0][bcs_pkg::FL_ZERO])
            |-> $past(ce && autoPulseSkipMode[0] && zeroCrossTrip[0]);
    endproperty
    a_zero_cross_cause: assert property (p_zero_cross_cause)
        else $error("zero-cross flag set outside pulse-skip trip");

    property p_read_clears;
        @(posedge clk) disable iff (!reset_n)
        (ce && clearFlags[0] && setFlags[0] == 4'h0) |=> flags[0] == 4'h0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("read did not clear latched flags");

    property p_live_bits;
        @(posedge clk) disable iff (!reset_n)
        (ce && readStrobe && hitTwo[0]) |=> readData[2:0] ==
            {$past(regulatorEnabled[0] & rampFinished[0]), $past(powerGoodCmp[0]),
             $past(regulatorEnabled[0])};
    endproperty
    a_live_bits: assert property (p_live_bits)
        else $error("live status bits wrong");

    property p_reaction;
        @(posedge clk) disable iff (!reset_n)
        (ce && setFlags[0][bcs_pkg::FL_RETRY])
            |=> retryRestart[0] == $past(retryResponseEnable)
                && retryLatchOff[0] == !$past(retryResponseEnable);
    endproperty
    a_reaction: assert property (p_reaction)
        else $error("retry reaction does not follow enable bit");

    ////////////////////////////////////////////////////////////////////////////
    // buck three checks, then further checks on flags, reactions, end count and read port
    property p_retry_set_three;
        @(posedge clk) disable iff (!reset_n)
        (ce && endReached[1] && !powerGoodCmp[1])
            |=> flags[1][bcs_pkg::FL_RETRY] && flags[1][bcs_pkg::FL_FAULT];
    endproperty
    a_retry_set_three: assert property (p_retry_set_three)
        else $error("buck three retry or fault flag not latched");

    property p_neg_limit_set;
        @(posedge clk) disable iff (!reset_n)
        (ce && negativeLimitHit[1]) |=> flags[1][bcs_pkg::FL_NEG];
    endproperty
    a_neg_limit_set: assert property (p_neg_limit_set)
        else $error("buck three negative limit not latched");

    property p_zero_cross_three;
        @(posedge clk) disable iff (!reset_n)
        (ce && autoPulseSkipMode[1] && zeroCrossTrip[1])
            |=> flags[1][bcs_pkg::FL_ZERO];
    endproperty
    a_zero_cross_three: assert property (p_zero_cross_three)
        else $error("buck three zero-cross trip not latched");

    // without pulse-skip mode a comparator trip must leave the flag low
    property p_zero_cross_blocked;
        @(posedge clk) disable iff (!reset_n)
        (ce && !autoPulseSkipMode[0] && !flags[0][bcs_pkg::FL_ZERO])
            |=> !flags[0][bcs_pkg::FL_ZERO];
    endproperty
    a_zero_cross_blocked: assert property (p_zero_cross_blocked)
        else $error("zero-cross flag set outside pulse-skip mode");

    property p_read_clears_three;
        @(posedge clk) disable iff (!reset_n)
        (ce && clearFlags[1] && setFlags[1] == 4'h0) |=> flags[1] == 4'h0;
    endproperty
    a_read_clears_three: assert property (p_read_clears_three)
        else $error("buck three read did not clear latched flags");

    property p_live_bits_three;
        @(posedge clk) disable iff (!reset_n)
        (ce && readStrobe && hitTwo[1]) |=> readData[2:0] ==
            {$past(regulatorEnabled[1] & rampFinished[1]), $past(powerGoodCmp[1]),
             $past(regulatorEnabled[1])};
    endproperty
    a_live_bits_three: assert property (p_live_bits_three)
        else $error("buck three live status bits wrong");

    property p_reaction_three;
        @(posedge clk) disable iff (!reset_n)
        (ce && setFlags[1][bcs_pkg::FL_RETRY])
            |=> retryRestart[1] == $past(retryResponseEnable)
                && retryLatchOff[1] == !$past(retryResponseEnable);
    endproperty
    a_reaction_three: assert property (p_reaction_three)
        else $error("buck three retry reaction does not follow enable bit");

    // the two reactions exclude each other on every channel
    property p_reaction_exclusive;
        @(posedge clk) disable iff (!reset_n)
        (retryRestart & retryLatchOff) == 2'h0;
    endproperty
    a_reaction_exclusive: assert property (p_reaction_exclusive)
        else $error("restart and latch-off raised together");

    // retry without fault would hide the event from software that polls fault only
    property p_retry_implies_fault;
        @(posedge clk) disable iff (!reset_n)
        !(flags[0][bcs_pkg::FL_RETRY] && !flags[0][bcs_pkg::FL_FAULT])
            && !(flags[1][bcs_pkg::FL_RETRY] && !flags[1][bcs_pkg::FL_FAULT]);
    endproperty
    a_retry_implies_fault: assert property (p_retry_implies_fault)
        else $error("retry flag latched without fault flag");

    // the end-count pulse only follows a counted event while power is not good
    property p_end_count_cause;
        @(posedge clk) disable iff (!reset_n)
        $rose(endReached[0])
            |-> $past(ce && highSideOvercurrent[0] && !powerGoodCmp[0]);
    endproperty
    a_end_count_cause: assert property (p_end_count_cause)
        else $error("end-count pulse without a counted event");

    // every enabled cycle answers: a read raises valid, an idle cycle zeroes the data
    property p_read_answer;
        @(posedge clk) disable iff (!reset_n)
        ce |=> readValid == $past(readStrobe)
            && (readValid || readData == 8'h00);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read port answer out of step");

    // a low clock enable freezes latched flags and the read port alike
    property p_freeze;
        @(posedge clk) disable iff (!reset_n)
        !ce |=> $stable(flags[0]) && $stable(flags[1])
            && $stable(readValid) && $stable(readData);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

endmodule // bcs_status_regs

// file: tb/tb_buck_channel_status_regs.sv
`timescale 1ns/100ps

module tb_buck_channel_status_regs;
    logic       clk;
    logic       reset_n;
    logic       ce;
    logic       readStrobe;
    logic [7:0] readAddr;
    logic [1:0] regulatorEnabled, rampFinished, powerGoodCmp, highSideOvercurrent;
    logic [1:0] negativeLimitHit, autoPulseSkipMode, zeroCrossTrip;
    logic       retryResponseEnable;
    logic [7:0] readData;
    logic       readValid;
    logic [1:0] retryRestart, retryLatchOff;
    int         n_mismatch;
    int         checks;
    int         nRestart;
    int         nLatchOff;

    bcs_status_regs uut (
        .clk(clk), .reset_n(reset_n), .ce(ce), .readStrobe(readStrobe),
        .readAddr(readAddr), .regulatorEnabled(regulatorEnabled),
        .rampFinished(rampFinished), .powerGoodCmp(powerGoodCmp),
        .highSideOvercurrent(highSideOvercurrent), .negativeLimitHit(negativeLimitHit),
        .autoPulseSkipMode(autoPulseSkipMode), .zeroCrossTrip(zeroCrossTrip),
        .retryResponseEnable(retryResponseEnable), .readData(readData),
        .readValid(readValid), .retryRestart(retryRestart), .retryLatchOff(retryLatchOff)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // reaction pulses are one cycle wide, so sampling at each falling edge counts each once
    always @(negedge clk) begin
        nRestart  += $countones(retryRestart);
        nLatchOff += $countones(retryLatchOff);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one read: strobe held across a single rising edge, answer awaited under a bound
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        int i;
        @(negedge clk);
        readStrobe <= 1'b1;
        readAddr   <= addr;
        @(negedge clk);
        readStrobe <= 1'b0;
        for (i = 0; i < 4 && readValid !== 1'b1; i++) @(negedge clk);
        chk("read valid", {7'h00, readValid}, 8'h01);
        chk("status byte", readData, exp);
    endtask

    // n overcurrent events, each a one-cycle pulse followed by a quiet cycle
    task automatic pulseOc(input int ch, input int n);
        repeat (n) begin
            @(negedge clk);
            highSideOvercurrent[ch] <= 1'b1;
            @(negedge clk);
            highSideOvercurrent[ch] <= 1'b0;
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a full run needs well under a thousand cycles; this leaves ample slack
    initial begin
        #(8 * 20000);
        n_mismatch++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, readStrobe, retryResponseEnable} = 3'h0;
        ce = 1'b1;
        readAddr = 8'h00;
        {regulatorEnabled, rampFinished, powerGoodCmp, highSideOvercurrent} = 8'h00;
        {negativeLimitHit, autoPulseSkipMode, zeroCrossTrip} = 6'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset_n <= 1'b1;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h00);
        // live bits per channel: soft-start-done needs the ramp as well as enable
        for (int ch = 0; ch < 2; ch++) begin
            regulatorEnabled[ch] <= 1'b1;
            powerGoodCmp[ch]     <= 1'b1;
            rd(bcs_pkg::ADDR_BUCK_TWO + 8'(ch), 8'h03);
            rampFinished[ch] <= 1'b1;
            rd(bcs_pkg::ADDR_BUCK_TWO + 8'(ch), 8'h07);
        end
        // enabled, ramped and not good latches the fault flag
        powerGoodCmp[0] <= 1'b0;
        repeat (2) @(negedge clk);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h85);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h85);
        powerGoodCmp[0] <= 1'b1;
        repeat (2) @(negedge clk);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h87);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h07);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h07);
        {regulatorEnabled, rampFinished, powerGoodCmp} <= 6'h00;
        // a single-cycle negative limit hit on buck three only
        negativeLimitHit[1] <= 1'b1;
        @(negedge clk);
        negativeLimitHit[1] <= 1'b0;
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h20);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h00);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        // a limit still present during the read keeps the flag for the next one
        negativeLimitHit[0] <= 1'b1;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h20);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h20);
        negativeLimitHit[0] <= 1'b0;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h20);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        // zero-cross trips count only in auto pulse-skip mode
        zeroCrossTrip <= 2'b11;
        repeat (3) @(negedge clk);
        zeroCrossTrip <= 2'b00;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        autoPulseSkipMode <= 2'b11;
        zeroCrossTrip     <= 2'b11;
        @(negedge clk);
        zeroCrossTrip <= 2'b00;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h10);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h10);
        autoPulseSkipMode <= 2'b00;
        // offsets outside the two status bytes read as zero
        rd(8'h05, 8'h00);
        rd(8'h08, 8'h00);
        // with the clock enable low neither reads nor events are taken
        @(negedge clk);
        ce               <= 1'b0;
        readStrobe       <= 1'b1;
        negativeLimitHit <= 2'b01;
        repeat (3) @(negedge clk);
        chk("valid while frozen", {7'h00, readValid}, 8'h00);
        {readStrobe, negativeLimitHit} <= 3'h0;
        ce <= 1'b1;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        // seven events are one short of the end count, the eighth ends it
        retryResponseEnable <= 1'b1;
        pulseOc(0, 7);
        chk("restart pulses", 8'(nRestart), 8'h00);
        pulseOc(0, 1);
        chk("restart pulses", 8'(nRestart), 8'h01);
        chk("latch-off pulses", 8'(nLatchOff), 8'h00);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'hC0);
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        retryResponseEnable <= 1'b0;
        pulseOc(1, 8);
        chk("latch-off pulses", 8'(nLatchOff), 8'h01);
        chk("restart pulses", 8'(nRestart), 8'h01);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'hC0);
        // power good in between restarts the count, so two runs of four never end it
        powerGoodCmp[1] <= 1'b1;
        @(negedge clk);
        powerGoodCmp[1] <= 1'b0;
        pulseOc(1, 4);
        powerGoodCmp[1] <= 1'b1;
        @(negedge clk);
        powerGoodCmp[1] <= 1'b0;
        pulseOc(1, 4);
        chk("latch-off pulses", 8'(nLatchOff), 8'h01);
        rd(bcs_pkg::ADDR_BUCK_THREE, 8'h00);
        // a reset in mid-run drops a freshly latched flag
        autoPulseSkipMode <= 2'h1;
        zeroCrossTrip     <= 2'h1;
        @(negedge clk);
        {autoPulseSkipMode, zeroCrossTrip} <= 4'h0;
        reset_n <= 1'b0;
        repeat (2) @(negedge clk);
        reset_n <= 1'b1;
        rd(bcs_pkg::ADDR_BUCK_TWO, 8'h00);
        end_of_test();
    end
endmodule // tb_buck_channel_status_regs
